// >>> safe_state_error_monitor_bench.sv
`timescale 1ns/10ps
module safe_state_error_monitor_bench;
    import ssm_pkg::*;
    typedef logic [89:0] ssm_obs_t;
    logic           CLK = 1'b0;
    logic           PARAM_CHK_DONE = 1'b0;
    logic           chk_stb = 1'b0;
    logic           NRST, ST_VALID, STIM_ERR, PARAM_CHK_OK, PARAM_SAVED, SAVED_ERR_IN;
    logic           CLEAR_REQ, CLEAR_AUTH, RELAY_REQ, DISP_PROG, sup_stuck, rel_stuck;
    logic           PARAM_CHK_START, ENC_SUPPLY_EN, EXT_RELAY_DRV, SAVE_ERR, ERASE_SAVED;
    logic           MON_EN, SAFE_STATE, RELAY_CLOSE, SPLIT_OE_N, LED_YELLOW, INIT_ERR;
    logic           RT_ERR, DISP_SHOW, DISP_CLASS, ENC_SUPPLY_SENSE, RELAY_FB, alarm;
    logic [15:0]    AOUT_REQ, AOUT_CODE;
    logic [31:0]    RT_FAULT, INIT_CODE, RT_CODE, DISP_CODE, acc;
    logic [2:0]     line;
    ssm_ctrl_t      CTRL_REQ, CTRL_OUT;
    ssm_split_t     SPLIT_REQ, SPLIT_OUT;
    ssm_int_fault_t ST_FAULTS;
    ssm_obs_t       exp_q[$];
    int             miscompares = 0;
    int             samples_checked = 0;
    int             k;
    int             pos[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 9, 10, 11, 12, 14};
    wire ssm_obs_t  seen = {SAFE_STATE, RELAY_CLOSE, AOUT_CODE, CTRL_OUT, INIT_CODE, RT_CODE};

    ssm_top #(.SETTLE_CYC(4), .TMO_CYC(8)) u_dut (
        .CLK, .NRST, .ST_VALID, .ST_FAULTS, .RT_FAULT, .STIM_ERR, .ENC_SUPPLY_SENSE,
        .RELAY_FB, .PARAM_CHK_DONE, .PARAM_CHK_OK, .PARAM_SAVED, .SAVED_ERR_IN,
        .CLEAR_REQ, .CLEAR_AUTH, .RELAY_REQ, .AOUT_REQ, .CTRL_REQ, .SPLIT_REQ,
        .DISP_PROG, .PARAM_CHK_START, .ENC_SUPPLY_EN, .EXT_RELAY_DRV, .SAVE_ERR,
        .ERASE_SAVED, .MON_EN, .SAFE_STATE, .RELAY_CLOSE, .AOUT_CODE, .CTRL_OUT,
        .SPLIT_OUT, .SPLIT_OE_N, .LED_YELLOW, .INIT_CODE, .RT_CODE, .INIT_ERR,
        .RT_ERR, .DISP_CODE, .DISP_SHOW, .DISP_CLASS
    );
    ssm_follower u_far (
        .sup_stuck, .rel_stuck, .enc_en(ENC_SUPPLY_EN), .rel_drv(EXT_RELAY_DRV),
        .relay(RELAY_CLOSE), .aout(AOUT_CODE), .split(SPLIT_OUT),
        .split_oe_n(SPLIT_OE_N), .sense(ENC_SUPPLY_SENSE), .fb(RELAY_FB), .line, .alarm
    );

    always #2.5 CLK = ~CLK;
    // Integrity check answers one cycle after its start
    always @(posedge CLK) PARAM_CHK_DONE <= #1 PARAM_CHK_START;

    task automatic check(input ssm_obs_t s, input ssm_obs_t e);
        samples_checked++;
        if (s !== e) begin
            miscompares++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask
    // One cycle per note; the monitor compares at mid-cycle
    task automatic note(input ssm_obs_t e);
        exp_q.push_back(e);
        chk_stb = 1'b1;
        @(negedge CLK);
        cyc(1);
        chk_stb = 1'b0;
    endtask
    always @(negedge CLK) begin
        if (chk_stb === 1'b1 && exp_q.size() > 0) begin
            check(seen, exp_q.pop_front());
        end
    end
    function automatic ssm_obs_t mk(logic s, logic [31:0] ic, logic [31:0] rc);
        return s ? {2'b10, 24'h0, ic, rc} : {2'b01, AOUT_REQ, CTRL_REQ, ic, rc};
    endfunction
    task automatic clr;
        CLEAR_AUTH = 1'b1;
        CLEAR_REQ = 1'b1;
        cyc(1);
        CLEAR_REQ = 1'b0;
        CLEAR_AUTH = 1'b0;
        check(90'(ERASE_SAVED), 90'(1));
        cyc(1);
    endtask
    task automatic do_reset(input logic f, input logic [31:0] want);
        int i;
        NRST = 1'b0;
        sup_stuck = f;
        rel_stuck = f;
        PARAM_CHK_OK = ~f;
        cyc(12);
        check(90'({SAFE_STATE, LED_YELLOW, SPLIT_OE_N, MON_EN}), 90'(4'hE));
        NRST = 1'b1;
        cyc(2);
        ST_VALID = 1'b1;
        cyc(1);
        ST_VALID = 1'b0;
        i = 0;
        while (!(f ? INIT_CODE === want : MON_EN === 1'b1) && i < 200) begin
            cyc(1);
            i++;
        end
        if (i == 200) begin
            miscompares++;
            test_done;
        end
    endtask

    initial begin
        {NRST, ST_VALID, STIM_ERR, PARAM_SAVED, SAVED_ERR_IN, CLEAR_REQ} = '0;
        {CLEAR_AUTH, RELAY_REQ, DISP_PROG, sup_stuck, rel_stuck, PARAM_CHK_OK} = '0;
        {AOUT_REQ, RT_FAULT, CTRL_REQ, SPLIT_REQ, ST_FAULTS} = '0;
        void'($urandom(13));
        do_reset(1'b0, 32'h0);
        RELAY_REQ = 1'b1;
        AOUT_REQ = 16'($urandom);
        CTRL_REQ = 8'($urandom);
        SPLIT_REQ = 3'($urandom);
        cyc(1);
        check(90'(line), 90'(SPLIT_REQ));
        note(mk(0, 0, 0));
        k = $urandom_range(29, 0);
        RT_FAULT = 32'h1 << k;
        // Let the combinational safe path settle before looking
        #1;
        check(90'({LED_YELLOW, SPLIT_OE_N, alarm, line}), 90'(6'h38));
        note(mk(1, 0, 0));
        RT_FAULT = '0;
        note(mk(1, 0, 32'h1 << k));
        DISP_PROG = 1'b1;
        cyc(2);
        check(90'({DISP_SHOW, DISP_CODE}), 90'(0));
        DISP_PROG = 1'b0;
        cyc(2);
        check(90'({DISP_SHOW, DISP_CLASS, RT_ERR, INIT_ERR, DISP_CODE}),
              90'({4'hA, 32'h1 << k}));
        // Clear without authorisation is ignored
        CLEAR_REQ = 1'b1;
        cyc(2);
        CLEAR_REQ = 1'b0;
        note(mk(1, 0, 32'h1 << k));
        clr;
        note(mk(0, 0, 0));
        STIM_ERR = 1'b1;
        note(mk(1, 0, 0));
        STIM_ERR = 1'b0;
        note(mk(0, 0, 0));
        acc = '0;
        repeat (8) begin
            RT_FAULT = $urandom & 32'h3FFF_FFFF;
            acc |= RT_FAULT;
            cyc(1);
        end
        RT_FAULT = '0;
        note(mk(1, 0, acc));
        // Power-up with the supply, relay and parameter checks failing and random internal self-test results
        ST_FAULTS = 13'($urandom);
        acc = 32'h0000_A100;
        foreach (pos[i]) begin
            if (ST_FAULTS[12 - i]) begin
                acc[pos[i]] = 1'b1;
            end
        end
        do_reset(1'b1, acc);
        note(mk(1, acc, 32'h4000_0000));
        check(90'({DISP_CLASS, DISP_CODE}), 90'({1'b1, acc}));
        clr;
        note(mk(1, 32'h8000, 32'h4000_0000));
        PARAM_SAVED = 1'b1;
        cyc(1);
        PARAM_SAVED = 1'b0;
        clr;
        note(mk(0, 0, 0));
        SAVED_ERR_IN = 1'b1;
        cyc(2);
        clr;
        note(mk(1, 32'h1_0000, 32'h4000_0000));
        check(90'({MON_EN, SAVE_ERR}), 90'(2'b01));
        SAVED_ERR_IN = 1'b0;
        clr;
        // Runtime mirror was re-raised by the clearing cycle itself
        note(mk(1, 0, 32'h4000_0000));
        clr;
        note(mk(0, 0, 0));
        test_done;
    end
    // Hang guard
    initial begin
        #400000;
        miscompares++;
        test_done;
    end
endmodule // safe_state_error_monitor_bench

// >>> ssm_asserts.sv
`timescale 1ns/10ps
module ssm_asserts #(
    parameter int AOUT_W = 16
) (
    input wire logic                CLK,
    input wire logic                NRST,
    input wire logic [31:0]         RT_FAULT,
    input wire logic                STIM_ERR,
    input wire logic                CLEAR_REQ,
    input wire logic                CLEAR_AUTH,
    input wire logic                PARAM_SAVED,
    input wire logic                DISP_PROG,
    input wire logic                ERASE_SAVED,
    input wire logic                SAFE_STATE,
    input wire logic                RELAY_CLOSE,
    input wire logic [AOUT_W-1:0]   AOUT_CODE,
    input wire ssm_pkg::ssm_ctrl_t  CTRL_OUT,
    input wire ssm_pkg::ssm_split_t SPLIT_OUT,
    input wire logic                SPLIT_OE_N,
    input wire logic                LED_YELLOW,
    input wire logic [31:0]         INIT_CODE,
    input wire logic [31:0]         RT_CODE,
    input wire logic                INIT_ERR,
    input wire logic [31:0]         DISP_CODE,
    input wire logic                DISP_SHOW
);
    import ssm_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    sequence s_clr_req;
        $rose(CLEAR_REQ) && CLEAR_AUTH;
    endsequence
    sequence s_erase;
        ERASE_SAVED ##1 !ERASE_SAVED;
    endsequence
    property p_relay; SAFE_STATE |-> !RELAY_CLOSE; endproperty
    property p_aout; SAFE_STATE |-> AOUT_CODE == '0; endproperty
    property p_ctrl; SAFE_STATE |-> CTRL_OUT == '0; endproperty
    property p_split; SAFE_STATE |-> SPLIT_OE_N && SPLIT_OUT == '0; endproperty
    property p_led; INIT_ERR || RT_CODE != '0 |-> LED_YELLOW && SAFE_STATE; endproperty
    property p_now; RT_FAULT != '0 || STIM_ERR |-> SAFE_STATE; endproperty
    property p_set;
        RT_FAULT != '0 |=> (RT_CODE & $past(RT_FAULT)) == $past(RT_FAULT);
    endproperty
    // Latched runtime bits only fall on an authorised clear
    property p_keep;
        !(CLEAR_REQ && CLEAR_AUTH) |=> (RT_CODE & $past(RT_CODE)) == $past(RT_CODE);
    endproperty
    property p_param; INIT_CODE[15] && !PARAM_SAVED |=> INIT_CODE[15]; endproperty
    property p_init_rt; INIT_ERR |-> RT_CODE[30]; endproperty
    property p_disp; DISP_PROG |=> !DISP_SHOW && DISP_CODE == '0; endproperty
    property p_cls; !DISP_PROG && INIT_ERR |=> DISP_CODE == $past(INIT_CODE); endproperty
    property p_clear; s_clr_req |=> s_erase; endproperty
    a_relay: assert property (p_relay) else $error("relay closed in safe state");
    a_aout: assert property (p_aout) else $error("current not zero");
    a_ctrl: assert property (p_ctrl) else $error("control output high");
    a_split: assert property (p_split) else $error("splitter not released");
    a_led: assert property (p_led) else $error("indicator off with error");
    a_now: assert property (p_now) else $error("safe state late");
    a_set: assert property (p_set) else $error("fault bit not latched");
    a_keep: assert property (p_keep) else $error("latched bit lost");
    a_param: assert property (p_param) else $error("parameter bit lost");
    a_init_rt: assert property (p_init_rt) else $error("no runtime mirror");
    a_disp: assert property (p_disp) else $error("shown in prog mode");
    a_cls: assert property (p_cls) else $error("init word not shown");
    a_clear: assert property (p_clear) else $error("erase pulse wrong");
endmodule // ssm_asserts
bind ssm_top ssm_asserts #(.AOUT_W(AOUT_W)) u_chk (
    .CLK, .NRST, .RT_FAULT, .STIM_ERR, .CLEAR_REQ, .CLEAR_AUTH, .PARAM_SAVED,
    .DISP_PROG, .ERASE_SAVED, .SAFE_STATE, .RELAY_CLOSE, .AOUT_CODE, .CTRL_OUT,
    .SPLIT_OUT, .SPLIT_OE_N, .LED_YELLOW, .INIT_CODE, .RT_CODE, .INIT_ERR,
    .DISP_CODE, .DISP_SHOW
);

// >>> ssm_defs.svh
`ifndef SSM_DEFS_SVH
`define SSM_DEFS_SVH
// Function
// - Any error opens the safety relay contact.
// - Any error drives the analogue current command to zero.
// - Any error drives all true and complement control outputs low.
// - Any error stops splitter pulses and releases its drivers to high impedance.
// - Yellow indicator stays lit steadily while an error is present.
// - Power-on and runtime errors are kept and reported as separate words.
// - Self-test runs on its own after reset, before monitoring starts.
// - Supply check failure sets its bit in the initialization word.
// - Digital output fault sets its bit in the initialization word.
// - Digital input fault sets its bit in the initialization word.
// - Analogue output path fault sets its bit in the initialization word.
// - Encoder supply is switched off and checked; failure sets its bit.
// - Splitter output test failure sets its bit in the initialization word.
// - External relay feedback is read back; wrong readback sets its bit.
// - Parameter integrity fault persists until a valid set is saved.
// - Saved error stays until erased and blocks normal operation.
// - Any initialization error also raises a runtime error.
// - Outside programming mode the active error goes to the display.

`define SSM_CLK_NS      5
`define SSM_SETTLE_NS   10000
`define SSM_SETTLE_CYC  ((`SSM_SETTLE_NS + `SSM_CLK_NS - 1) / `SSM_CLK_NS)
`define SSM_TMO_NS      20000
`define SSM_TMO_CYC     (`SSM_TMO_NS / `SSM_CLK_NS)

`define SSM_CODE_RST    32'h0000_0000

`define SSM_IB_CONV     0
`define SSM_IB_SBUS     1
`define SSM_IB_SUPPLY   2
`define SSM_IB_SERIAL   3
`define SSM_IB_DOUT     4
`define SSM_IB_DIN      5
`define SSM_IB_CAPT     6
`define SSM_IB_AOUT     7
`define SSM_IB_ENCSUP   8
`define SSM_IB_SPLIT    9
`define SSM_IB_CPU      10
`define SSM_IB_RAM      11
`define SSM_IB_WDOG     12
`define SSM_IB_EXTREL   13
`define SSM_IB_NVS      14
`define SSM_IB_PARAM    15
`define SSM_IB_SAVED    16
`define SSM_RB_INIT     30
`endif

// >>> ssm_err_latch.sv
`timescale 1ns/10ps
`include "ssm_defs.svh"
module ssm_err_latch #(
    parameter int W = 32
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] set_bits,
    input  wire logic [W-1:0] clr_bits,
    output logic      [W-1:0] code
);
    logic [W-1:0] code_reg;
    logic [W-1:0] code_next;

    // sticky accumulate
    // Set beats clear so an event in the clearing cycle survives
    assign code_next = set_bits | (code_reg & ~clr_bits);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            code_reg <= W'(`SSM_CODE_RST);
        end else begin
            code_reg <= code_next;
        end
    end

    assign code = code_reg;
endmodule // ssm_err_latch

// >>> ssm_follower.sv
`timescale 1ns/10ps
module ssm_follower (
    input wire logic                sup_stuck,
    input wire logic                rel_stuck,
    input wire logic                enc_en,
    input wire logic                rel_drv,
    input wire logic                relay,
    input wire logic [15:0]         aout,
    input wire ssm_pkg::ssm_split_t split,
    input wire logic                split_oe_n,
    output logic                    sense,
    output logic                    fb,
    output logic [2:0]              line,
    output logic                    alarm
);
    import ssm_pkg::*;
    assign sense = enc_en | sup_stuck;
    // contactor follows drive, may stick open
    assign fb = rel_drv & ~rel_stuck;
    assign line = split_oe_n ? 3'h0 : split;
    assign alarm = !relay && aout == 16'h0 && line == 3'h0;
endmodule // ssm_follower

// >>> ssm_pkg.sv
package ssm_pkg;
    typedef struct packed {
        logic converter;
        logic serial_bus;
        logic supply_check_fault;
        logic serial_link_fault;
        logic digital_output_fault;
        logic digital_input_fault;
        logic capture_unit_fault;
        logic analog_path_fault;
        logic splitter_output_fault;
        logic processor;
        logic memory;
        logic watchdog_fault;
        logic nonvolatile_store_fault;
    } ssm_int_fault_t;

    typedef struct packed {
        logic [3:0] ctrl_out_true;
        logic [3:0] ctrl_out_complement;
    } ssm_ctrl_t;

    typedef struct packed {
        logic trk_a;
        logic trk_b;
        logic trk_z;
    } ssm_split_t;

    typedef enum logic [6:0] {
        ST_BOOT    = 7'b0000001,
        ST_SUP_OFF = 7'b0000010,
        ST_REL_ON  = 7'b0000100,
        ST_REL_OFF = 7'b0001000,
        ST_PARAM   = 7'b0010000,
        ST_WAIT    = 7'b0100000,
        ST_RUN     = 7'b1000000
    } ssm_state_t;
endpackage

// >>> ssm_sync.sv
`timescale 1ns/10ps
module ssm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         nrst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s1_reg <= '0;
            s2_reg <= '0;
        end else begin
            s1_reg <= d;
            s2_reg <= s1_reg;
        end
    end

    assign q = s2_reg;
endmodule // ssm_sync

// >>> ssm_top.sv
`timescale 1ns/10ps
`include "ssm_defs.svh"
module ssm_top #(
    parameter int SETTLE_CYC = `SSM_SETTLE_CYC,
    parameter int TMO_CYC    = `SSM_TMO_CYC,
    parameter int AOUT_W     = 16
) (
    input  wire logic                    CLK,
    input  wire logic                    NRST,
    input  wire logic                    ST_VALID,
    input  wire ssm_pkg::ssm_int_fault_t ST_FAULTS,
    input  wire logic [31:0]             RT_FAULT,
    input  wire logic                    STIM_ERR,
    input  wire logic                    ENC_SUPPLY_SENSE,
    input  wire logic                    RELAY_FB,
    input  wire logic                    PARAM_CHK_DONE,
    input  wire logic                    PARAM_CHK_OK,
    input  wire logic                    PARAM_SAVED,
    input  wire logic                    SAVED_ERR_IN,
    input  wire logic                    CLEAR_REQ,
    input  wire logic                    CLEAR_AUTH,
    input  wire logic                    RELAY_REQ,
    input  wire logic [AOUT_W-1:0]       AOUT_REQ,
    input  wire ssm_pkg::ssm_ctrl_t      CTRL_REQ,
    input  wire ssm_pkg::ssm_split_t     SPLIT_REQ,
    input  wire logic                    DISP_PROG,
    output logic                         PARAM_CHK_START,
    output logic                         ENC_SUPPLY_EN,
    output logic                         EXT_RELAY_DRV,
    output logic                         SAVE_ERR,
    output logic                         ERASE_SAVED,
    output logic                         MON_EN,
    output logic                         SAFE_STATE,
    output logic                         RELAY_CLOSE,
    output logic [AOUT_W-1:0]            AOUT_CODE,
    output ssm_pkg::ssm_ctrl_t           CTRL_OUT,
    output ssm_pkg::ssm_split_t          SPLIT_OUT,
    output logic                         SPLIT_OE_N,
    output logic                         LED_YELLOW,
    output logic [31:0]                  INIT_CODE,
    output logic [31:0]                  RT_CODE,
    output logic                         INIT_ERR,
    output logic                         RT_ERR,
    output logic [31:0]                  DISP_CODE,
    output logic                         DISP_SHOW,
    output logic                         DISP_CLASS
);
    import ssm_pkg::*;

    localparam int TMAX  = (SETTLE_CYC > TMO_CYC) ? SETTLE_CYC : TMO_CYC;
    localparam int CNT_W = $clog2(TMAX + 1);

    // Internal test results placed at their own word positions
    function automatic logic [31:0] map_int(input ssm_int_fault_t f);
        logic [31:0] w;
        w = `SSM_CODE_RST;
        w[`SSM_IB_CONV]   = f.converter;
        w[`SSM_IB_SBUS]   = f.serial_bus;
        w[`SSM_IB_SERIAL] = f.serial_link_fault;
        w[`SSM_IB_CAPT]   = f.capture_unit_fault;
        w[`SSM_IB_CPU]    = f.processor;
        w[`SSM_IB_RAM]    = f.memory;
        w[`SSM_IB_WDOG]   = f.watchdog_fault;
        w[`SSM_IB_NVS]    = f.nonvolatile_store_fault;
        w[`SSM_IB_SUPPLY] = f.supply_check_fault;
        w[`SSM_IB_DOUT]   = f.digital_output_fault;
        w[`SSM_IB_DIN]    = f.digital_input_fault;
        w[`SSM_IB_AOUT]   = f.analog_path_fault;
        w[`SSM_IB_SPLIT]  = f.splitter_output_fault;
        return w;
    endfunction

    ssm_state_t          state_reg;
    ssm_state_t          state_next;
    logic [CNT_W-1:0]    cnt_reg;
    logic [CNT_W-1:0]    cnt_next;
    logic                int_seen_reg;
    logic                int_seen_next;
    logic                clear_req_reg;
    logic                cnt_clr;
    logic                chk_sup;
    logic                chk_rel_on;
    logic                chk_rel_off;
    logic                param_bad;
    logic                int_tmo;
    logic                param_start;
    logic                settle_hit;
    logic                tmo_hit;
    logic                sup_sense;
    logic                rel_fb;
    logic [1:0]          pin_sync;
    logic                clr_pulse;
    logic [31:0]         own_set;
    logic [31:0]         init_set;
    logic [31:0]         init_clr;
    logic [31:0]         rt_set;
    logic [31:0]         rt_clr;
    logic [31:0]         init_q;
    logic [31:0]         rt_q;
    logic                err_now;
    logic                safe;
    logic                run;
    logic                relay_reg;
    logic [AOUT_W-1:0]   aout_reg;
    ssm_ctrl_t           ctrl_reg;
    ssm_split_t          split_reg;
    logic [31:0]         disp_code_reg;
    logic [31:0]         disp_code_next;
    logic                disp_show_reg;
    logic                disp_class_reg;
    logic                disp_class_next;
    logic                erase_reg;

    // Supply sense and relay feedback are pins
    ssm_sync #(
        .W (2)
    ) u_pin_sync (
        .clk  (CLK),
        .nrst (NRST),
        .d    ({ENC_SUPPLY_SENSE, RELAY_FB}),
        .q    (pin_sync)
    );

    assign sup_sense  = pin_sync[1];
    assign rel_fb     = pin_sync[0];
    assign settle_hit = (cnt_reg == CNT_W'(SETTLE_CYC - 1));
    assign tmo_hit    = (cnt_reg == CNT_W'(TMO_CYC - 1));
    assign run        = (state_reg == ST_RUN);

    always_comb begin
        state_next  = state_reg;
        cnt_clr     = 1'b0;
        chk_sup     = 1'b0;
        chk_rel_on  = 1'b0;
        chk_rel_off = 1'b0;
        param_bad   = 1'b0;
        int_tmo     = 1'b0;
        param_start = 1'b0;
        unique case (state_reg)
            ST_BOOT: begin
                state_next = ST_SUP_OFF;
                cnt_clr    = 1'b1;
            end
            ST_SUP_OFF: begin
                if (settle_hit) begin
                    chk_sup    = 1'b1;
                    state_next = ST_REL_ON;
                    cnt_clr    = 1'b1;
                end
            end
            ST_REL_ON: begin
                if (settle_hit) begin
                    chk_rel_on = 1'b1;
                    state_next = ST_REL_OFF;
                    cnt_clr    = 1'b1;
                end
            end
            ST_REL_OFF: begin
                if (settle_hit) begin
                    chk_rel_off = 1'b1;
                    param_start = 1'b1;
                    state_next  = ST_PARAM;
                    cnt_clr     = 1'b1;
                end
            end
            ST_PARAM: begin
                if (PARAM_CHK_DONE) begin
                    param_bad  = ~PARAM_CHK_OK;
                    state_next = ST_WAIT;
                    cnt_clr    = 1'b1;
                end else if (tmo_hit) begin
                    // A check that never answers counts as failed
                    param_bad  = 1'b1;
                    state_next = ST_WAIT;
                    cnt_clr    = 1'b1;
                end
            end
            ST_WAIT: begin
                if (int_seen_reg || ST_VALID) begin
                    state_next = ST_RUN;
                end else if (tmo_hit) begin
                    int_tmo    = 1'b1;
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                state_next = ST_RUN;
            end
        endcase
    end

    assign cnt_next      = cnt_clr ? '0 : (tmo_hit && settle_hit) ? cnt_reg :
                           (cnt_reg == CNT_W'(TMAX)) ? cnt_reg : cnt_reg + 1'b1;
    assign int_seen_next = int_seen_reg | ST_VALID;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg    <= ST_BOOT;
            cnt_reg      <= '0;
            int_seen_reg <= 1'b0;
        end else begin
            state_reg    <= state_next;
            cnt_reg      <= cnt_next;
            int_seen_reg <= int_seen_next;
        end
    end

    // Self-test actuators
    // supply switched off
    assign ENC_SUPPLY_EN   = (state_reg != ST_SUP_OFF);
    assign EXT_RELAY_DRV   = (state_reg == ST_REL_ON);
    assign PARAM_CHK_START = param_start;

    // Checks performed by the sequencer itself
    always_comb begin
        own_set = `SSM_CODE_RST;
        own_set[`SSM_IB_ENCSUP] = chk_sup & sup_sense;
        own_set[`SSM_IB_EXTREL] = (chk_rel_on & ~rel_fb) | (chk_rel_off & rel_fb);
        own_set[`SSM_IB_PARAM]  = param_bad;
        // Missing internal results blamed on the processor
        own_set[`SSM_IB_CPU]    = int_tmo;
        own_set[`SSM_IB_SAVED]  = SAVED_ERR_IN;
    end

    assign clr_pulse = CLEAR_REQ & ~clear_req_reg & CLEAR_AUTH;

    assign init_set = own_set | (ST_VALID ? map_int(ST_FAULTS) : `SSM_CODE_RST);

    always_comb begin
        init_clr = {32{clr_pulse}};
        // only a saved set clears it
        init_clr[`SSM_IB_PARAM] = PARAM_SAVED;
    end

    always_comb begin
        rt_set = RT_FAULT;
        rt_set[`SSM_RB_INIT] = RT_FAULT[`SSM_RB_INIT] | (|init_q) | (|init_set);
    end

    assign rt_clr = {32{clr_pulse}};

    ssm_err_latch #(
        .W (32)
    ) u_init_latch (
        .clk      (CLK),
        .nrst     (NRST),
        .set_bits (init_set),
        .clr_bits (init_clr),
        .code     (init_q)
    );

    ssm_err_latch #(
        .W (32)
    ) u_rt_latch (
        .clk      (CLK),
        .nrst     (NRST),
        .set_bits (rt_set),
        .clr_bits (rt_clr),
        .code     (rt_q)
    );

    assign err_now = (|init_set) | (|rt_set) | (|init_q) | (|rt_q) | STIM_ERR;
    // Outputs stay safe until monitoring has begun
    assign safe    = err_now | ~run;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            clear_req_reg <= 1'b0;
            erase_reg     <= 1'b0;
            relay_reg     <= 1'b0;
            aout_reg      <= '0;
            ctrl_reg      <= '0;
            split_reg     <= '0;
        end else begin
            clear_req_reg <= CLEAR_REQ;
            erase_reg     <= clr_pulse;
            relay_reg     <= RELAY_REQ;
            aout_reg      <= AOUT_REQ;
            ctrl_reg      <= CTRL_REQ;
            split_reg     <= SPLIT_REQ;
        end
    end

    // Gating after the registers keeps the reaction in the same cycle
    // relay opens
    assign RELAY_CLOSE = relay_reg & ~safe;
    assign AOUT_CODE   = safe ? '0 : aout_reg;
    assign CTRL_OUT    = safe ? '0 : ctrl_reg;
    assign SPLIT_OUT   = safe ? '0 : split_reg;
    assign SPLIT_OE_N  = safe;
    assign LED_YELLOW  = safe;

    assign SAFE_STATE  = safe;
    assign MON_EN      = run & ~err_now & ~SAVED_ERR_IN;
    assign SAVE_ERR    = (|init_q) | (|rt_q);
    assign ERASE_SAVED = erase_reg;
    assign INIT_CODE   = init_q;
    assign RT_CODE     = rt_q;
    assign INIT_ERR    = |init_q;
    assign RT_ERR      = |rt_q;

    assign disp_class_next = |init_q;
    assign disp_code_next  = DISP_PROG ? `SSM_CODE_RST : (|init_q) ? init_q : rt_q;

    always_ff @(posedge CLK or negedge NRST) begin
        if (!NRST) begin
            disp_code_reg  <= `SSM_CODE_RST;
            disp_show_reg  <= 1'b0;
            disp_class_reg <= 1'b0;
        end else begin
            disp_code_reg  <= disp_code_next;
            disp_show_reg  <= ~DISP_PROG & ((|init_q) | (|rt_q));
            disp_class_reg <= disp_class_next;
        end
    end

    assign DISP_CODE  = disp_code_reg;
    assign DISP_SHOW  = disp_show_reg;
    assign DISP_CLASS = disp_class_reg;
endmodule // ssm_top
